// ===== rtl/irq_mask_prio.v
// Overview of operation
// - Mask bit 7 is a global gate; clear blocks every source.
// - Global gate overrides each individual source mask bit.
// - Mask bit 6 gates all SPI interrupt causes.
// - Mask bit 5 gates timer 2; either overflow flag may request.
// - Mask bit 4 gates the UART request.
// - Mask bit 3 gates the timer 1 overflow flag.
// - Mask bit 2 gates external line 1.
// - Mask bit 1 gates the timer 0 overflow flag.
// - Mask bit 0 gates external line 0.
// - Level registers bit 7 reads one; writes to it are dropped.
// - Low level register bits 6..0 hold each source's level LSB.
// - High level register bits 6..0 hold each source's level MSB.
// - All three registers on every page, bit and byte access.
// - High and low bits form a level 0..3, 3 highest.
// - Service preempted only by a strictly higher level request.
// - Highest level among simultaneous requests is serviced first.
// - Equal levels: ext0, timer0, ext1, timer1, UART, timer2, SPI.
`timescale 1ns/1ps
`include "irq_mask_prio_defs.vh"

module irq_mask_prio
(
    // Clock and reset
    input  wire        clock,
    input  wire        rst,
    // Special-function register port
    input  wire [7:0]  sfr_addr,
    input  wire        sfr_write,
    input  wire        sfr_read,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_bit_op,
    input  wire [2:0]  sfr_bit_sel,
    output reg  [7:0]  sfr_rdata,
    output reg         sfr_hit,
    // Peripheral pending flags
    input  wire        ext_line0,
    input  wire        timer0_overflow_flag,
    input  wire        ext_line1,
    input  wire        timer1_overflow_flag,
    input  wire        uart_pending,
    input  wire        timer2_low_overflow_flag,
    input  wire        timer2_high_overflow_flag,
    input  wire        spi_pending,
    // Sequencer handshake
    input  wire        irq_ack,
    input  wire        irq_return,
    output reg         irq_request,
    output reg  [2:0]  irq_source,
    output reg  [1:0]  irq_level,
    output reg  [3:0]  in_service
);

    reg  [7:0] irq_mask_reg;
    reg  [7:0] irq_level_low_reg;
    reg  [7:0] irq_level_high_reg;

    wire       global_irq_gate  = irq_mask_reg[`BIT_GLOBAL_GATE];
    wire       spi_irq_mask_bit = irq_mask_reg[`BIT_SPI];
    wire       timer2_irq_mask  = irq_mask_reg[`BIT_TIMER2];
    wire       uart_irq_mask    = irq_mask_reg[`BIT_UART];
    wire       timer1_irq_mask  = irq_mask_reg[`BIT_TIMER1];
    wire       ext1_irq_mask    = irq_mask_reg[`BIT_EXT1];
    wire       timer0_irq_mask  = irq_mask_reg[`BIT_TIMER0];
    wire       ext0_irq_mask    = irq_mask_reg[`BIT_EXT0];

    // Pending flags in fixed tie order, index 0 wins
    wire [6:0] pending;
    assign pending[0] = ext_line0;
    assign pending[1] = timer0_overflow_flag;
    assign pending[2] = ext_line1;
    assign pending[3] = timer1_overflow_flag;
    assign pending[4] = uart_pending;
    assign pending[5] = timer2_low_overflow_flag | timer2_high_overflow_flag;
    assign pending[6] = spi_pending;

    wire [6:0] source_mask;
    assign source_mask[0] = ext0_irq_mask;
    assign source_mask[1] = timer0_irq_mask;
    assign source_mask[2] = ext1_irq_mask;
    assign source_mask[3] = timer1_irq_mask;
    assign source_mask[4] = uart_irq_mask;
    assign source_mask[5] = timer2_irq_mask;
    assign source_mask[6] = spi_irq_mask_bit;

    // Gate overrides every source mask
    wire [6:0] gated = pending & source_mask & {7{global_irq_gate}};

    wire       found;
    wire [2:0] winner;
    wire [1:0] winner_level;

    irq_level_decode u_decode
    (
        .request      (gated),
        .level_low    (irq_level_low_reg[6:0]),
        .level_high   (irq_level_high_reg[6:0]),
        .found        (found),
        .winner       (winner),
        .winner_level (winner_level)
    );

    // Highest level currently in service, or none
    reg        active;
    reg  [1:0] active_level;
    integer    k;

    always @*
    begin
        active       = 1'b0;
        active_level = 2'h0;
        for (k = 0; k < 4; k = k + 1)
        begin
            if (in_service[k])
            begin
                active       = 1'b1;
                active_level = k[1:0];
            end
        end
    end

    // Level 3 never preempted since nothing exceeds it
    wire next_request = found && (!active || winner_level > active_level);

    // Register decode; page bits are not part of the address
    wire hit_mask = (sfr_addr == `ADDR_IRQ_MASK);
    wire hit_low  = (sfr_addr == `ADDR_IRQ_LEVEL_LOW);
    wire hit_high = (sfr_addr == `ADDR_IRQ_LEVEL_HIGH);

    // Merge a single-bit write into the current value
    function [7:0] merge;
        input [7:0] old;
        input [7:0] wdata;
        input       bit_op;
        input [2:0] sel;
        reg   [7:0] result;
        begin
            result = old;
            if (bit_op)
                result[sel] = wdata[0];
            else
                result = wdata;
            merge = result;
        end
    endfunction

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            irq_mask_reg       <= `RESET_IRQ_MASK;
            irq_level_low_reg  <= `RESET_IRQ_LEVEL;
            irq_level_high_reg <= `RESET_IRQ_LEVEL;
        end
        else if (sfr_write)
        begin
            if (hit_mask)
                irq_mask_reg <= merge(irq_mask_reg, sfr_wdata, sfr_bit_op, sfr_bit_sel);
            if (hit_low)
                irq_level_low_reg <= merge(irq_level_low_reg, sfr_wdata, sfr_bit_op,
                                           sfr_bit_sel) | `RESET_IRQ_LEVEL;
            if (hit_high)
                irq_level_high_reg <= merge(irq_level_high_reg, sfr_wdata, sfr_bit_op,
                                            sfr_bit_sel) | `RESET_IRQ_LEVEL;
        end
    end

    // Read data: byte, or selected bit in bit 0
    reg [7:0] selected;
    always @*
    begin
        if (hit_mask)
            selected = irq_mask_reg;
        else if (hit_low)
            selected = irq_level_low_reg;
        else if (hit_high)
            selected = irq_level_high_reg;
        else
            selected = 8'h00;
    end

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end
        else
        begin
            sfr_hit <= sfr_read & (hit_mask | hit_low | hit_high);
            if (sfr_read)
                sfr_rdata <= sfr_bit_op ? {7'h00, selected[sfr_bit_sel]} : selected;
            else
                sfr_rdata <= 8'h00;
        end
    end

    // Request to sequencer and in-service tracking
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            irq_request <= 1'b0;
            irq_source  <= 3'h0;
            irq_level   <= 2'h0;
            in_service  <= 4'h0;
        end
        else
        begin
            irq_request <= next_request & ~irq_ack;
            irq_source  <= winner;
            irq_level   <= winner_level;
            // An acknowledge raises the level; otherwise a return retires the highest
            if (irq_ack && irq_request)
                in_service[irq_level] <= 1'b1;
            else if (irq_return && active)
                in_service[active_level] <= 1'b0;
        end
    end

endmodule

// ===== rtl/irq_mask_prio_defs.vh
`ifndef IRQ_MASK_PRIO_DEFS_VH
`define IRQ_MASK_PRIO_DEFS_VH

// Special-function register addresses, reachable from every page
`define ADDR_IRQ_LEVEL_HIGH  8'h84
`define ADDR_IRQ_MASK        8'hA8
`define ADDR_IRQ_LEVEL_LOW   8'hB8

// Reset values
`define RESET_IRQ_MASK       8'h00
`define RESET_IRQ_LEVEL      8'h80

// Mask register fields
`define BIT_GLOBAL_GATE      7
`define BIT_SPI              6
`define BIT_TIMER2           5
`define BIT_UART             4
`define BIT_TIMER1           3
`define BIT_EXT1             2
`define BIT_TIMER0           1
`define BIT_EXT0             0

// Level registers: bit 7 always reads one
`define BIT_LEVEL_FIXED      7

`define NUM_SOURCES          7

`endif

// ===== rtl/irq_level_decode.v
`timescale 1ns/1ps
`include "irq_mask_prio_defs.vh"

// Picks the highest-level active request; ties go to the lowest index
module irq_level_decode
(
    // Requests and their levels
    input  wire [`NUM_SOURCES-1:0]     request,
    input  wire [`NUM_SOURCES-1:0]     level_low,
    input  wire [`NUM_SOURCES-1:0]     level_high,
    // Winner
    output reg                         found,
    output reg  [2:0]                  winner,
    output reg  [1:0]                  winner_level
);

    integer i;
    reg [1:0] lvl;

    always @*
    begin
        found        = 1'b0;
        winner       = 3'h0;
        winner_level = 2'h0;
        lvl          = 2'h0;
        // Scan from highest index down so lower indices win ties
        for (i = `NUM_SOURCES - 1; i >= 0; i = i - 1)
        begin
            lvl = {level_high[i], level_low[i]};
            if (request[i] && (!found || lvl >= winner_level))
            begin
                found        = 1'b1;
                winner       = i[2:0];
                winner_level = lvl;
            end
        end
    end

endmodule

// ===== tb/irq_core_model.sv
`timescale 1ns/1ps
// Core sequencer: takes a standing request after a chosen wait
module irq_core_model
(
    // Clock and reset
    input  wire       clock,
    input  wire       rst,
    // Bench control
    input  wire       take,
    input  wire [3:0] wait_cycles,
    input  wire       retire,
    // Block handshake
    input  wire       irq_request,
    output reg        irq_ack,
    output reg        irq_return
);
    reg [3:0] count;
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            count <= 4'h0;
        end
        else
        begin
            // Never acks twice running, so a dropped request is not taken again
            irq_ack <= take && irq_request && !irq_ack && count == wait_cycles;
            count <= (irq_request && !irq_ack && count != wait_cycles) ? count + 4'h1 : 4'h0;
            irq_return <= retire;
        end
    end
endmodule

// ===== tb/irq_mask_prio_sva.sv
`timescale 1ns/1ps
`include "irq_mask_prio_defs.vh"
module irq_mask_prio_sva
(
    // Clock and reset
    input wire       clock,
    input wire       rst,
    // Register port
    input wire [7:0] sfr_addr,
    input wire       sfr_read,
    input wire       sfr_bit_op,
    input wire [7:0] sfr_rdata,
    input wire       sfr_hit,
    // Sequencer
    input wire       irq_ack,
    input wire       irq_return,
    input wire       irq_request,
    input wire [2:0] irq_source,
    input wire [1:0] irq_level,
    input wire [3:0] in_service
);
    wire lvl_reg = sfr_addr == `ADDR_IRQ_LEVEL_HIGH || sfr_addr == `ADDR_IRQ_LEVEL_LOW;
    wire mapped = lvl_reg || sfr_addr == `ADDR_IRQ_MASK;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_hit_after_read: assert property (sfr_hit |-> $past(sfr_read))
        else $error("hit without read");
    a_rdata_quiet: assert property (!$past(sfr_read) |-> sfr_rdata == 8'h00)
        else $error("read data while idle");
    a_unmapped_miss: assert property (sfr_read && !mapped |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("unmapped read answered");
    a_level_msb_one: assert property (sfr_read && !sfr_bit_op && lvl_reg |=> sfr_rdata[7])
        else $error("level register bit 7 low");
    a_ack_drops_req: assert property (irq_ack && irq_request |=> !irq_request)
        else $error("request stands after ack");
    a_ack_marks_level: assert property (irq_ack && irq_request |=>
        in_service == ($past(in_service) | (4'h1 << $past(irq_level))))
        else $error("ack did not mark level");
    a_only_higher: assert property (irq_request |-> (in_service >> irq_level) == 4'h0)
        else $error("request not above service");
    a_source_range: assert property (irq_request |-> irq_source <= 3'h6)
        else $error("bad source index");
    a_return_retires: assert property (irq_return && !irq_ack && in_service[3] |=>
        !in_service[3])
        else $error("return kept top level");
endmodule
bind irq_mask_prio irq_mask_prio_sva irq_mask_prio_sva_i (.clock(clock), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_read(sfr_read), .sfr_bit_op(sfr_bit_op), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .irq_ack(irq_ack), .irq_return(irq_return), .irq_request(irq_request),
    .irq_source(irq_source), .irq_level(irq_level), .in_service(in_service));

// ===== tb/legacy_irq_mask_and_priority_test.sv
`timescale 1ns/1ps
`include "irq_mask_prio_defs.vh"
module legacy_irq_mask_and_priority_test;
    reg        clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bop = 1'b0;
    reg        take = 1'b0, retire = 1'b0;
    reg [7:0]  addr = 8'h00, wdata = 8'h00, pend = 8'h00;
    reg [2:0]  bsel = 3'h0;
    reg [37:0] rows [0:14];
    wire [7:0] rdata;
    wire [3:0] insv;
    wire [2:0] src;
    wire [1:0] lvl;
    wire       hit, req, ack, ret;
    integer    err_total = 0, n_compared = 0, i;
    always #10 clock = ~clock;
    irq_mask_prio irq_mask_prio_i (.clock(clock), .rst(rst), .sfr_addr(addr), .sfr_write(wr),
        .sfr_read(rd), .sfr_wdata(wdata), .sfr_bit_op(bop), .sfr_bit_sel(bsel), .sfr_rdata(rdata),
        .sfr_hit(hit), .ext_line0(pend[0]), .timer0_overflow_flag(pend[1]), .ext_line1(pend[2]),
        .timer1_overflow_flag(pend[3]), .uart_pending(pend[4]), .timer2_low_overflow_flag(pend[5]),
        .timer2_high_overflow_flag(pend[6]), .spi_pending(pend[7]), .irq_ack(ack),
        .irq_return(ret), .irq_request(req), .irq_source(src), .irq_level(lvl), .in_service(insv));
    irq_core_model irq_core_model_i (.clock(clock), .rst(rst), .take(take), .wait_cycles(4'h2),
        .retire(retire), .irq_request(req), .irq_ack(ack), .irq_return(ret));
    task chk(input [7:0] got, input [7:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("Error %0t: saw %h expected %h", $time, got, exp);
        end
    end
    endtask
    task step(input integer n);
    begin
        repeat (n) @(posedge clock);
        #1;
    end
    endtask
    // Strobes stay up between accesses so no strobe is set twice in one step
    task acc(input w, input [7:0] a, input [7:0] d, input b, input [2:0] s, input [7:0] e);
        reg mapped;
    begin
        mapped = (a == `ADDR_IRQ_MASK) || (a == `ADDR_IRQ_LEVEL_LOW)
                 || (a == `ADDR_IRQ_LEVEL_HIGH);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        bop = b;
        bsel = s;
        step(1);
        if (!w) chk(rdata, e);
        if (!w) chk({7'h00, hit}, {7'h00, mapped});
    end
    endtask
    task levels(input [7:0] m, input [7:0] l, input [7:0] h);
    begin
        acc(1'b1, `ADDR_IRQ_MASK, m, 1'b0, 3'h0, 8'h00);
        acc(1'b1, `ADDR_IRQ_LEVEL_LOW, l, 1'b0, 3'h0, 8'h00);
        acc(1'b1, `ADDR_IRQ_LEVEL_HIGH, h, 1'b0, 3'h0, 8'h00);
        wr = 1'b0;
    end
    endtask
    task test_done;
    begin
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        #20000;
        err_total = err_total + 1;
        test_done;
    end
    initial
    begin
        // Mask, low, high, pending, then request/source/level expected
        rows[0] = {8'h00, 8'h00, 8'h00, 8'h01, 6'h00};
        rows[1] = {8'h7F, 8'h00, 8'h00, 8'hFF, 6'h00};
        rows[2] = {8'h81, 8'h00, 8'h00, 8'h01, 6'h20};
        rows[3] = {8'h82, 8'h00, 8'h00, 8'h02, 6'h24};
        rows[4] = {8'h84, 8'h00, 8'h00, 8'h04, 6'h28};
        rows[5] = {8'h88, 8'h00, 8'h00, 8'h08, 6'h2C};
        rows[6] = {8'h90, 8'h00, 8'h00, 8'h10, 6'h30};
        rows[7] = {8'hA0, 8'h00, 8'h00, 8'h20, 6'h34};
        rows[8] = {8'hA0, 8'h00, 8'h00, 8'h40, 6'h34};
        rows[9] = {8'hC0, 8'h00, 8'h00, 8'h80, 6'h38};
        rows[10] = {8'hBF, 8'h00, 8'h00, 8'h80, 6'h00};
        rows[11] = {8'hFF, 8'h00, 8'h00, 8'hFF, 6'h20};
        rows[12] = {8'hFF, 8'h40, 8'h40, 8'hFF, 6'h3B};
        rows[13] = {8'hFF, 8'h20, 8'h00, 8'hFF, 6'h35};
        rows[14] = {8'hFF, 8'h00, 8'h10, 8'hFF, 6'h32};
        repeat (10) @(posedge clock);
        #1 rst = 1'b0;
        acc(1'b0, `ADDR_IRQ_MASK, 8'h00, 1'b0, 3'h0, 8'h00);
        acc(1'b0, `ADDR_IRQ_LEVEL_LOW, 8'h00, 1'b0, 3'h0, 8'h80);
        acc(1'b0, `ADDR_IRQ_LEVEL_HIGH, 8'h00, 1'b0, 3'h0, 8'h80);
        acc(1'b0, 8'h85, 8'h00, 1'b0, 3'h0, 8'h00);
        acc(1'b1, `ADDR_IRQ_LEVEL_HIGH, 8'h00, 1'b0, 3'h0, 8'h00);
        acc(1'b0, `ADDR_IRQ_LEVEL_HIGH, 8'h00, 1'b0, 3'h0, 8'h80);
        acc(1'b1, `ADDR_IRQ_MASK, 8'h01, 1'b1, 3'h7, 8'h00);
        acc(1'b0, `ADDR_IRQ_MASK, 8'h00, 1'b1, 3'h7, 8'h01);
        acc(1'b0, `ADDR_IRQ_MASK, 8'h00, 1'b0, 3'h0, 8'h80);
        for (i = 0; i < 15; i = i + 1)
        begin
            levels(rows[i][37:30], rows[i][29:22], rows[i][21:14]);
            pend = rows[i][13:6];
            step(2);
            chk({2'h0, req, src, lvl}, {2'h0, rows[i][5:0]});
            pend = 8'h00;
            step(2);
        end
        // Level 0 in service blocks peers until a higher level arrives
        levels(8'hFF, 8'h00, 8'h00);
        take = 1'b1;
        pend = 8'h01;
        step(8);
        chk({3'h0, req, insv}, 8'h01);
        levels(8'hFF, 8'h40, 8'h40);
        pend = 8'h81;
        step(8);
        chk({3'h0, req, insv}, 8'h09);
        take = 1'b0;
        retire = 1'b1;
        step(1);
        retire = 1'b0;
        step(3);
        chk({4'h0, insv}, 8'h01);
        // Reset in mid-run must clear service state, the mask and the low level register
        pend = 8'h00;
        rst = 1'b1;
        step(2);
        chk({3'h0, req, insv}, 8'h00);
        rst = 1'b0;
        acc(1'b0, `ADDR_IRQ_MASK, 8'h00, 1'b0, 3'h0, 8'h00);
        acc(1'b0, `ADDR_IRQ_LEVEL_LOW, 8'h00, 1'b0, 3'h0, 8'h80);
        test_done;
    end
endmodule
